// *** common/sleep_defs.svh ***
// timing and encoding constants for the block sleep interface
`ifndef SLEEP_DEFS_SVH
`define SLEEP_DEFS_SVH

// clock rate of the manager and of the blocks, in MHz
`define SLP_CLK_MHZ 50
// cycles for which every sleep request is held low after a wake event
`define SLP_WAKE_CLEAR_CYCLES 4
// longest time a busy block may take to finish before sleeping, in us
`define SLP_FINISH_MAX_US 1000
// the same time in cycles; a longest time rounds down
`define SLP_FINISH_MAX_CYCLES (`SLP_FINISH_MAX_US * `SLP_CLK_MHZ)
// vendor test command that reads the sleep indicator
`define SLP_TAP_CMD_SLEEP 8'h07
// bit position of the sleep indicator in that command's answer
`define SLP_TAP_SLEEPING_BIT 1
// default segment layout
`define SLP_SEGS 2
`define SLP_PER_SEG 4

`endif

// *** common/sleep_pkg.sv ***
// types shared by the power manager and the block end
package sleep_pkg;

  // chip sleep state selected by the system sleep control field
  typedef enum logic [1:0] {
    HEAVY_SLEEP_1 = 2'b00,
    HEAVY_SLEEP_2 = 2'b01,
    HEAVY_SLEEP_3 = 2'b10,
    DEEPEST_SLEEP = 2'b11
  } sleep_state_t;

  // power manager sequencing
  typedef enum logic [1:0] {
    PM_RUN = 2'b00,
    PM_SLEEP = 2'b01,
    PM_WAKE = 2'b10
  } pm_state_t;

endpackage

// *** common/sleep_if.sv ***
// sleep interface between the power manager and the peripheral blocks
`timescale 1ns/1ns
interface sleep_if #(
  parameter int SEGS = 2,
  parameter int PER_SEG = 4
);
  localparam int N = SEGS * PER_SEG;
  // block index is seg * PER_SEG + position in segment
  logic [N-1:0] sleep_en;
  logic [N-1:0] clk_req;
  logic [N-1:0] reset_en;

  modport pm (output sleep_en, output reset_en, input clk_req);
  modport blk (input sleep_en, input reset_en, output clk_req);
endinterface

// *** rtl/sleep_block_end.sv ***
// block side of the sleep interface, one lane per peripheral block
`timescale 1ns/1ns
`include "sleep_defs.svh"
module sleep_block_end import sleep_pkg::*; #(
  parameter int SEGS = `SLP_SEGS,
  parameter int PER_SEG = `SLP_PER_SEG,
  // set bits mark simple blocks such as timers and pwms
  parameter logic [SEGS*PER_SEG-1:0] SIMPLE_MASK = '0,
  parameter int FINISH_MAX_CYCLES = `SLP_FINISH_MAX_CYCLES
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // sleep interface
  sleep_if.blk link,
  // block user side
  input wire logic [SEGS*PER_SEG-1:0] work_pending,
  input wire logic [SEGS*PER_SEG-1:0] reg_access,
  output logic [SEGS*PER_SEG-1:0] block_clk_en,
  output logic [SEGS*PER_SEG-1:0] block_reset,
  output logic [SEGS*PER_SEG-1:0] block_asleep,
  output logic [SEGS*PER_SEG-1:0] finish_overrun
);
  localparam int N = SEGS * PER_SEG;
  localparam int CW = $clog2(FINISH_MAX_CYCLES + 1);

  logic [N-1:0] busy;
  logic [N-1:0] demand;

  for (genvar i = 0; i < N; i++) begin : g_lane
    logic [CW-1:0] finish_cnt;
    logic finish_late;

    // simple blocks never hold the clock for work once sleep is asked
    assign busy[i] = work_pending[i] & ~(SIMPLE_MASK[i] & link.sleep_en[i]);
    assign finish_late = (finish_cnt == CW'(FINISH_MAX_CYCLES));

    // lock in sleep once idle under a request; freed only by a low request
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        block_asleep[i] <= 1'b0;
      end else if (!link.sleep_en[i]) begin
        block_asleep[i] <= 1'b0;
      end else if (!busy[i] || finish_late) begin
        block_asleep[i] <= 1'b1;
      end
    end

    // time the finishing of work under a sleep request
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        finish_cnt <= '0;
      end else if (link.sleep_en[i] && busy[i] && !block_asleep[i] && !finish_late) begin
        finish_cnt <= finish_cnt + CW'(1);
      end else if (!link.sleep_en[i]) begin
        finish_cnt <= '0;
      end
    end

    // overrun flag stays until the request falls
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        finish_overrun[i] <= 1'b0;
      end else if (!link.sleep_en[i]) begin
        finish_overrun[i] <= 1'b0;
      end else if (finish_late && !block_asleep[i]) begin
        finish_overrun[i] <= 1'b1;
      end
    end

    // reset the block on the cycle it falls asleep if asked to
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        block_reset[i] <= 1'b0;
      end else begin
        block_reset[i] <= link.reset_en[i] & link.sleep_en[i] & ~block_asleep[i]
          & (~busy[i] | finish_late);
      end
    end
  end

  // demand: work raises it from the input itself, so no clock edge is needed;
  // locking in sleep and a request reaching a simple block are the synchronous lowerings
  assign demand = busy & ~block_asleep;
  // register access always wins, whatever the request
  assign link.clk_req = demand | reg_access;
  // internal clock runs only while demand or register access stands
  assign block_clk_en = link.clk_req;

endmodule // sleep_block_end

// *** rtl/power_manager.sv ***
// central power manager: block sleep requests, chip sleep states, wake
`timescale 1ns/1ns
`include "sleep_defs.svh"
module power_manager import sleep_pkg::*; #(
  parameter int SEGS = `SLP_SEGS,
  parameter int PER_SEG = `SLP_PER_SEG,
  parameter int WAKE_CLEAR_CYCLES = `SLP_WAKE_CLEAR_CYCLES
) (
  // clock and standby-domain system reset
  input wire logic clk,
  input wire logic arst_n,
  // sleep interface to the blocks
  sleep_if.pm blocks,
  // firmware controls
  input wire logic [SEGS*PER_SEG-1:0] block_sleep_enable,
  input wire logic [SEGS*PER_SEG-1:0] reset_on_sleep,
  input wire logic sleep_all,
  input wire sleep_state_t system_sleep_control,
  input wire logic cpu_sleep_exec,
  input wire logic wake_irq_clear,
  // firmware status
  output logic [SEGS*PER_SEG-1:0] clk_required_status,
  output logic wake_irq,
  // wake sources from outside the clock domain
  input wire logic wake_event,
  input wire logic wake_irq_group,
  input wire logic wake_only_group,
  // chip test access port, arriving from the debug pins
  input wire logic tap_proc_access,
  input wire logic tap_cmd_valid,
  input wire logic [7:0] vendor_test_command,
  output logic [7:0] tap_read_data,
  // oscillator control and probe, chip sleep flag and latched sleep state
  input wire logic osc_probe_enable,
  output logic osc_enable,
  output logic osc_probe_output,
  output logic chip_sleeping,
  output sleep_state_t active_sleep_state
);
  localparam int N = SEGS * PER_SEG;
  localparam int AW = N + 5;
  localparam int WCW = $clog2(WAKE_CLEAR_CYCLES + 1);

  pm_state_t state;
  pm_state_t next_state;
  logic [AW-1:0] async_in;
  logic [AW-1:0] sync_a;
  logic [AW-1:0] sync_b;
  logic [AW-1:0] sync_c;
  logic [AW-1:0] filt;
  logic [AW-1:0] filt_q;
  logic [N-1:0] req_sync;
  logic [N-1:0] cmd_vec;
  logic wake_rise;
  logic irq_rise;
  logic only_rise;
  logic tap_rise;
  logic cmd_rise;
  logic wake_any;
  logic all_cmd;
  logic none_req;
  logic [WCW-1:0] wake_cnt;
  logic tap_read_hit;

  // every input from outside the domain except the test command byte, demand lines included
  assign async_in = {blocks.clk_req, wake_event, wake_irq_group, wake_only_group,
                     tap_proc_access, tap_cmd_valid};

  // three-stage capture per bit; a change counts once stages two and three agree
  for (genvar i = 0; i < AW; i++) begin : g_sync
    always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
        sync_a[i] <= 1'b0;
        sync_b[i] <= 1'b0;
        sync_c[i] <= 1'b0;
        filt[i] <= 1'b0;
      end else begin
        sync_a[i] <= async_in[i];
        sync_b[i] <= sync_a[i];
        sync_c[i] <= sync_b[i];
        if (sync_b[i] == sync_c[i]) begin
          filt[i] <= sync_c[i];
        end
      end
    end
  end

  // previous filtered values for edge detection
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      filt_q <= '0;
    end else begin
      filt_q <= filt;
    end
  end

  assign req_sync = filt[AW-1:5];
  assign wake_rise = filt[4] & ~filt_q[4];
  assign irq_rise = filt[3] & ~filt_q[3];
  assign only_rise = filt[2] & ~filt_q[2];
  assign tap_rise = filt[1] & ~filt_q[1];
  assign cmd_rise = filt[0] & ~filt_q[0];
  // every wake source, debug access to the processor included
  assign wake_any = wake_rise | irq_rise | only_rise | tap_rise;

  // sleep everything by the global bit or by every block bit
  assign cmd_vec = block_sleep_enable | {N{sleep_all}};
  assign all_cmd = &cmd_vec;
  assign none_req = ~|req_sync;

  // state sequencing
  always_comb begin
    next_state = state;
    unique case (state)
      PM_RUN: begin
        if (wake_any) begin
          next_state = PM_WAKE;
        end else if (all_cmd && none_req && cpu_sleep_exec) begin
          next_state = PM_SLEEP;
        end
      end
      PM_SLEEP: begin
        // only a wake source leaves; power-on is the reset itself
        if (wake_any) begin
          next_state = PM_WAKE;
        end
      end
      PM_WAKE: begin
        if (wake_cnt == WCW'(1)) begin
          next_state = PM_RUN;
        end
      end
      default: begin
        next_state = PM_RUN;
      end
    endcase
  end

  // state register
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      state <= PM_RUN;
    end else begin
      state <= next_state;
    end
  end

  // length of the momentary clear; a new wake restarts it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_cnt <= '0;
    end else if (wake_any) begin
      wake_cnt <= WCW'(WAKE_CLEAR_CYCLES);
    end else if (wake_cnt != '0) begin
      wake_cnt <= wake_cnt - WCW'(1);
    end
  end

  // requests follow the programmed bits, forced low during the wake clear;
  // the programmed bits are never touched, so the restore is automatic
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blocks.sleep_en <= '0;
    end else if (next_state == PM_WAKE) begin
      blocks.sleep_en <= '0;
    end else begin
      blocks.sleep_en <= cmd_vec;
    end
  end

  // reset-on-sleep selection passed straight to each block
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      blocks.reset_en <= '0;
    end else begin
      blocks.reset_en <= reset_on_sleep;
    end
  end

  // per-block status mirrors the synchronised demand
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      clk_required_status <= '0;
    end else begin
      clk_required_status <= req_sync;
    end
  end

  // sleep state is latched on entry so a later write cannot change it mid-sleep
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      active_sleep_state <= HEAVY_SLEEP_1;
    end else if (state == PM_RUN && next_state == PM_SLEEP) begin
      active_sleep_state <= system_sleep_control;
    end
  end

  // oscillator keeps running only in heavy sleep 1, for a short wake latency
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_enable <= 1'b1;
      chip_sleeping <= 1'b0;
    end else begin
      osc_enable <= (next_state != PM_SLEEP) ||
        (state == PM_RUN ? system_sleep_control : active_sleep_state) == HEAVY_SLEEP_1;
      chip_sleeping <= next_state == PM_SLEEP;
    end
  end

  // probe toggles each cycle while running; frozen once asleep
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      osc_probe_output <= 1'b0;
    end else if (osc_probe_enable && state != PM_SLEEP) begin
      osc_probe_output <= ~osc_probe_output;
    end
  end

  // only the wake group interrupts the processor; firmware just clears it
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      wake_irq <= 1'b0;
    end else if (irq_rise) begin
      wake_irq <= 1'b1;
    end else if (wake_irq_clear) begin
      wake_irq <= 1'b0;
    end
  end

  // sleep indicator read; a read is not a wake source, so sleep is untouched.
  // limitation: the real port answers on its own clock, this one needs clk
  assign tap_read_hit = cmd_rise && vendor_test_command == `SLP_TAP_CMD_SLEEP;
  always_ff @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      tap_read_data <= 8'h00;
    end else if (tap_read_hit) begin
      tap_read_data <= 8'h00;
      tap_read_data[`SLP_TAP_SLEEPING_BIT] <= state == PM_SLEEP;
    end
  end

endmodule // power_manager

// *** tb/sleep_monitor.sv ***
// concurrent checks on the sleep interface and the manager's chip-level outputs
`timescale 1ns/1ns
module sleep_monitor import sleep_pkg::*; #(
  parameter int SEGS = 2,
  parameter int PER_SEG = 4
) (
  // clock and reset
  input wire logic clk,
  input wire logic arst_n,
  // sleep interface lanes
  input wire logic [SEGS*PER_SEG-1:0] sleep_en,
  input wire logic [SEGS*PER_SEG-1:0] clk_req,
  input wire logic [SEGS*PER_SEG-1:0] reset_en,
  // manager firmware side
  input wire logic [SEGS*PER_SEG-1:0] block_sleep_enable,
  input wire logic [SEGS*PER_SEG-1:0] reset_on_sleep,
  input wire logic sleep_all,
  input wire sleep_state_t system_sleep_control,
  input wire logic cpu_sleep_exec,
  input wire logic [SEGS*PER_SEG-1:0] clk_required_status,
  // chip sleep outputs
  input wire logic chip_sleeping,
  input wire logic osc_enable,
  input wire logic osc_probe_output,
  input wire sleep_state_t active_sleep_state,
  // block end user side
  input wire logic [SEGS*PER_SEG-1:0] reg_access,
  input wire logic [SEGS*PER_SEG-1:0] block_asleep,
  input wire logic [SEGS*PER_SEG-1:0] block_reset
);
  localparam int N = SEGS * PER_SEG;
  logic [N-1:0] cmd;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);

  // commanded vector as the manager should sample it
  assign cmd = block_sleep_enable | {N{sleep_all}};

  property p_req_follow;
    (sleep_en != '0) |-> (sleep_en == $past(cmd));
  endproperty
  a_req_follow: assert property (p_req_follow)
    else $error("sleep request differs from command");

  // first edge after release still shows the reset value
  property p_reset_copy;
    $past(arst_n) |-> (reset_en == $past(reset_on_sleep));
  endproperty
  a_reset_copy: assert property (p_reset_copy)
    else $error("reset select not copied");

  property p_reset_pulse;
    (block_reset != '0) |-> ((block_reset & ~(block_asleep & ~$past(block_asleep)
      & $past(reset_en))) == '0);
  endproperty
  a_reset_pulse: assert property (p_reset_pulse)
    else $error("block reset outside sleep entry");

  // a seven-sample window covers the three sync stages, filter and status flop
  property p_status_sync;
    $stable(clk_req) [*7] |-> (clk_required_status == clk_req);
  endproperty
  a_status_sync: assert property (p_status_sync)
    else $error("clock status does not follow demand");

  property p_asleep_quiet;
    ((clk_req & block_asleep & ~reg_access) == '0) && ((block_asleep & ~$past(sleep_en)) == '0);
  endproperty
  a_asleep_quiet: assert property (p_asleep_quiet)
    else $error("sleeping block demands clock");

  property p_entry;
    $rose(chip_sleeping) |-> $past(cpu_sleep_exec) && $past(&cmd)
      && (active_sleep_state == $past(system_sleep_control));
  endproperty
  a_entry: assert property (p_entry)
    else $error("chip sleep entry without its conditions");

  property p_osc;
    osc_enable == (!chip_sleeping || active_sleep_state == HEAVY_SLEEP_1);
  endproperty
  a_osc: assert property (p_osc)
    else $error("oscillator enable wrong for state");

  property p_probe;
    (chip_sleeping && $past(chip_sleeping)) |-> $stable(osc_probe_output);
  endproperty
  a_probe: assert property (p_probe)
    else $error("probe moves while sleeping");

  property p_wake_clear;
    $fell(chip_sleeping) |-> (sleep_en == '0) [*4] ##1 (sleep_en == $past(cmd));
  endproperty
  a_wake_clear: assert property (p_wake_clear)
    else $error("wake clear of requests wrong");
endmodule // sleep_monitor

// *** tb/block_sleep_clock_gating_manager_tb_top.sv ***
// testbench joining the power manager and the block end through the sleep interface
`timescale 1ns/1ns
module block_sleep_clock_gating_manager_tb_top import sleep_pkg::*;;
  logic clk = 0;
  logic arst_n = 0;
  logic [7:0] block_sleep_enable, reset_on_sleep, clk_required_status, tap_read_data;
  logic [7:0] vendor_test_command, work_pending, reg_access;
  logic [7:0] block_clk_en, block_reset, block_asleep, finish_overrun;
  logic sleep_all, cpu_sleep_exec, wake_irq_clear, wake_irq, tap_cmd_valid, osc_probe_enable;
  logic osc_enable, osc_probe_output, chip_sleeping, p;
  logic [3:0] wk;
  sleep_state_t system_sleep_control, active_sleep_state;
  int fail_count = 0;
  int n_checks = 0;
  int cycles = 0;

  // 50 MHz clock
  always #10 clk = ~clk;

  // segment layout and wake clear length are left at their defaults
  sleep_if lk ();

  power_manager u_power_manager (
    .clk, .arst_n, .blocks(lk), .block_sleep_enable, .reset_on_sleep, .sleep_all,
    .system_sleep_control, .cpu_sleep_exec, .wake_irq_clear, .clk_required_status,
    .wake_irq, .wake_event(wk[3]), .wake_irq_group(wk[0]), .wake_only_group(wk[1]),
    .tap_proc_access(wk[2]), .tap_cmd_valid, .vendor_test_command, .tap_read_data,
    .osc_probe_enable, .osc_enable, .osc_probe_output, .chip_sleeping, .active_sleep_state);

  // bit 7 is a simple block; short finish bound keeps the run brief
  sleep_block_end #(.SIMPLE_MASK(8'h80), .FINISH_MAX_CYCLES(40))
    u_sleep_block_end (
    .clk, .arst_n, .link(lk), .work_pending, .reg_access, .block_clk_en, .block_reset,
    .block_asleep, .finish_overrun);

  sleep_monitor u_sleep_monitor (
    .clk, .arst_n, .sleep_en(lk.sleep_en), .clk_req(lk.clk_req), .reset_en(lk.reset_en),
    .block_sleep_enable, .reset_on_sleep, .sleep_all, .system_sleep_control,
    .cpu_sleep_exec, .clk_required_status, .chip_sleeping, .osc_enable, .osc_probe_output,
    .active_sleep_state, .reg_access, .block_asleep, .block_reset);

  task check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    n_checks++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task complete_run();
    if (fail_count == 0 && n_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // bounded wait on the chip sleep flag
  task wait_for(input logic want);
    int k;
    k = 0;
    while (chip_sleeping !== want && k < 100) begin
      @(negedge clk);
      k++;
    end
    check("chip_sleeping", chip_sleeping, want);
  endtask

  // hang guard, far above the expected run of about 140 cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      fail_count++;
      complete_run();
    end
  end

  initial begin
    {block_sleep_enable, sleep_all, cpu_sleep_exec, wake_irq_clear, wk} = '0;
    {tap_cmd_valid, vendor_test_command, reg_access} = '0;
    reset_on_sleep = 8'h0F;
    system_sleep_control = HEAVY_SLEEP_2;
    osc_probe_enable = 1'b1;
    work_pending = 8'h82;
    repeat (16) @(negedge clk);
    arst_n = 1'b1;
    repeat (2) @(negedge clk);
    check("reset_en", lk.reset_en, 8'h0F);
    check("osc_enable", osc_enable, 1'b1);
    check("block_clk_en", block_clk_en, 8'h82);
    p = osc_probe_output;
    @(negedge clk);
    // logical not keeps the expected toggle one bit wide
    check("probe", osc_probe_output, !p);
    sleep_all = 1'b1;
    repeat (2) @(negedge clk);
    check("sleep_en all", lk.sleep_en, 8'hFF);
    sleep_all = 1'b0;
    repeat (8) @(negedge clk);
    check("sleep_en", lk.sleep_en, 8'h00);
    check("status", clk_required_status, 8'h82);
    block_sleep_enable = 8'hFF;
    repeat (2) @(negedge clk);
    check("asleep", block_asleep, 8'hFD);
    check("clk_req", lk.clk_req, 8'h02);
    check("reset pulse", block_reset, 8'h0D);
    // the simple block's drop has not crossed the synchroniser yet
    check("status lag", clk_required_status, 8'h82);
    cpu_sleep_exec = 1'b1;
    repeat (10) @(negedge clk);
    check("busy blocks sleep", chip_sleeping, 1'b0);
    check("status busy", clk_required_status, 8'h02);
    work_pending = 8'h00;
    wait_for(1'b1);
    check("asleep all", block_asleep, 8'hFF);
    check("overrun", finish_overrun, 8'h00);
    check("state", active_sleep_state, HEAVY_SLEEP_2);
    check("osc_enable", osc_enable, 1'b0);
    reg_access = 8'h08;
    // demand must rise with no clock edge in between
    #1;
    check("async demand", lk.clk_req, 8'h08);
    @(negedge clk);
    check("access demand", lk.clk_req, 8'h08);
    check("access clock", block_clk_en, 8'h08);
    reg_access = 8'h00;
    @(negedge clk);
    check("demand after access", lk.clk_req, 8'h00);
    vendor_test_command = 8'h07;
    tap_cmd_valid = 1'b1;
    repeat (8) @(negedge clk);
    check("tap data", tap_read_data, 8'h02);
    check("still asleep", chip_sleeping, 1'b1);
    tap_cmd_valid = 1'b0;
    // each wake source in turn, re-entering a different sleep state
    for (int i = 0; i < 4; i++) begin
      system_sleep_control = sleep_state_t'(i);
      wk[i] = 1'b1;
      wait_for(1'b0);
      check("wake clear", lk.sleep_en, 8'h00);
      @(negedge clk);
      check("wake_irq", wake_irq, 8'(i == 0));
      wk[i] = 1'b0;
      wake_irq_clear = 1'b1;
      @(negedge clk);
      wake_irq_clear = 1'b0;
      wait_for(1'b1);
      check("irq cleared", wake_irq, 1'b0);
      check("restored", lk.sleep_en, 8'hFF);
      check("state", active_sleep_state, 8'(i));
      check("osc_enable", osc_enable, 8'(i == 0));
    end
    // a block that never finishes is forced asleep at the finish bound
    cpu_sleep_exec = 1'b0;
    block_sleep_enable = 8'h00;
    work_pending = 8'h02;
    repeat (2) @(negedge clk);
    check("busy demand", lk.clk_req, 8'h02);
    block_sleep_enable = 8'hFF;
    repeat (41) @(negedge clk);
    check("still finishing", block_asleep, 8'hFD);
    @(negedge clk);
    check("forced asleep", block_asleep, 8'hFF);
    check("overrun set", finish_overrun, 8'h02);
    check("demand dropped", lk.clk_req, 8'h00);
    complete_run();
  end
endmodule // block_sleep_clock_gating_manager_tb_top
